// file: conv_frontend_model.sv
`timescale 1ns/1ps
// stands in for the converter: answers a few cycles after each start
module conv_frontend_model
  import temp_regs_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        conv_start,
  input wire logic [12:0] temp_in,
  output conv_res_s       conv
);
  logic [2:0] cnt_r;
  // temp toggles while idle so a stale sample cannot pass as fresh
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 3'h0;
      conv  <= '0;
    end else begin
      conv.valid <= (cnt_r == 3'h1);
      conv.temp  <= (cnt_r == 3'h1) ? temp_in : ~conv.temp;
      cnt_r      <= conv_start ? 3'h4 : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
    end
  end
endmodule

// file: temp_regs_pkg.sv
package temp_regs_pkg;

  localparam logic [1:0]  PTR_RESULT    = 2'h0;
  localparam logic [1:0]  PTR_CONFIG    = 2'h1;
  localparam logic [1:0]  PTR_LOW       = 2'h2;
  localparam logic [1:0]  PTR_HIGH      = 2'h3;

  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [15:0] CONFIG_RESET  = 16'h0200;
  localparam logic [15:0] LOW_RESET     = 16'hF600;
  localparam logic [15:0] HIGH_RESET    = 16'h3C00;

  localparam int          INT_EN_BIT    = 15;
  localparam int          RATE_HI_BIT   = 14;
  localparam int          RATE_LO_BIT   = 13;
  localparam int          OVER_BIT      = 12;
  localparam int          UNDER_BIT     = 11;
  localparam int          LATCH_BIT     = 10;
  localparam int          MODE_HI_BIT   = 9;
  localparam int          MODE_LO_BIT   = 8;
  localparam int          EXT_BIT       = 7;
  localparam int          EM_BIT        = 3;

  // writable configuration bits: 15:13, 10:7
  localparam logic [15:0] CONFIG_WMASK  = 16'hE780;
  localparam logic [15:0] THR_MASK_STD  = 16'hFFF0;
  localparam logic [15:0] THR_MASK_EXT  = 16'hFFF8;

  localparam logic [1:0]  MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0]  MODE_SINGLE   = 2'h1;

  // conversion periods in ms for rate codes 00..11
  localparam int          CLK_HZ        = 100000000;
  localparam int          PERIOD_MS_0   = 4000;
  localparam int          PERIOD_MS_1   = 1000;
  localparam int          PERIOD_MS_2   = 250;
  localparam int          PERIOD_MS_3   = 125;
  localparam logic [31:0] PERIOD_CYC_0  = 32'(64'(PERIOD_MS_0) * CLK_HZ / 1000);
  localparam logic [31:0] PERIOD_CYC_1  = 32'(64'(PERIOD_MS_1) * CLK_HZ / 1000);
  localparam logic [31:0] PERIOD_CYC_2  = 32'(64'(PERIOD_MS_2) * CLK_HZ / 1000);
  localparam logic [31:0] PERIOD_CYC_3  = 32'(64'(PERIOD_MS_3) * CLK_HZ / 1000);

  // register access request from the link decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  ptr;
    logic [15:0] wdata;
  } reg_req_s;

  // finished conversion from the analog front end
  typedef struct packed {
    logic        valid;
    logic [12:0] temp;
  } conv_res_s;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_WAIT,
    CONV_BUSY
  } conv_state_e;

endpackage

// file: temp_sensor_register_set.sv
`timescale 1ns/1ps
// Contract
// R1 - 2-bit pointer picks one of four registers
// R2 - negative temperatures are two's complement
// R3 - result reads zero until first conversion
// R4 - normal mode: 12-bit result in 15:4
// R5 - extended mode: 13-bit result, low three zero
// R6 - config bit 15 is interrupt enable
// R7 - config bits 14:13 select conversion rate
// R8 - over flag set when result above high
// R9 - under flag set when result below low
// R10 - bit 10 selects clear-on-read or latched flags
// R11 - bits 9:8 select shutdown, single, continuous
// R12 - bit 7 selects 12 or 13-bit layout
// R13 - configuration resets to 0200h
// R14 - low threshold 12-bit, resets F60h
// R15 - low threshold 13-bit in 15:3
// R16 - high threshold 12-bit, resets 3C0h
// R17 - threshold defaults meaningful only in 12-bit
// R18 - ignore bit 3 writes when extended off
// R19 - host rewrites thresholds after mode change
// R20 - registers shifted least significant bit first
// R21 - host puts pointer in command bits 2:1
// R22 - single converts once, continuous runs periodically
module temp_sensor_register_set
  import temp_regs_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      resetn,
  input  wire reg_req_s  req,
  input  wire conv_res_s conv,
  output logic [15:0]    rdata,
  output logic           rvalid,
  output logic           conv_start,
  output logic           int_enable,
  output logic           extended_range_select
);

  // register state, next values, decoded fields and strobes
  logic [15:0] result_r,   result_nxt;
  logic [15:0] config_r,   config_nxt;
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic [15:0] rdata_r,    rdata_nxt;
  logic        rvalid_r,   rvalid_nxt;
  logic        start_r,    start_nxt;
  logic [31:0] timer_r,    timer_nxt;
  conv_state_e state_r,    state_nxt;
  logic [31:0] period;
  logic        ext;
  logic        over_limit_flag;
  logic        under_limit_flag;
  logic [15:0] conv_word;
  logic [15:0] thr_mask;
  logic        flags_read;
  logic        rd_req;
  logic        cfg_wr;
  logic        low_wr;
  logic        high_wr;
  logic        conv_done;
  logic        continuous;
  logic        single_shot;
  logic        single_done_r, single_done_nxt;

  assign ext = config_r[EXT_BIT]; // R12

  // both layouts keep the 1/16 degree step; normal drops the top bit,
  // so values beyond the 12-bit range wrap there
  always_comb begin
    if (ext) begin
      conv_word = {conv.temp, 3'h0}; // R5 R2
    end else begin
      conv_word = {conv.temp[11:0], 4'h0}; // R4 R2
    end
  end

  // limit compares use signed values; bit 3 is zero in normal layout
  assign over_limit_flag  = $signed(conv_word) > $signed(high_r & thr_mask); // R8
  assign under_limit_flag = $signed(conv_word) < $signed(low_r & thr_mask);  // R9

  // extended indicator bit only survives a write in extended mode
  assign thr_mask   = ext ? THR_MASK_EXT : THR_MASK_STD; // R18 R15
  assign flags_read = req.valid && !req.write && req.ptr == PTR_CONFIG;

  // request strobes; the result register has no write strobe, it is read-only
  assign rd_req  = req.valid && !req.write;
  assign cfg_wr  = req.valid && req.write && req.ptr == PTR_CONFIG;
  assign low_wr  = req.valid && req.write && req.ptr == PTR_LOW;
  assign high_wr = req.valid && req.write && req.ptr == PTR_HIGH;

  // an answer that arrives outside a conversion is dropped
  assign conv_done = conv.valid && state_r == CONV_BUSY;

  // read port; with bit 10 clear, a configuration read also clears the flags further down
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (rd_req) begin
      rvalid_nxt = 1'b1;
      case (req.ptr) // R1
        PTR_RESULT: rdata_nxt = result_r;
        PTR_CONFIG: rdata_nxt = config_r;
        PTR_LOW:    rdata_nxt = low_r;
        PTR_HIGH:   rdata_nxt = high_r;
        default:    rdata_nxt = 16'h0000;
      endcase
    end
  end

  // rdata is bit-parallel and holds until the next read, so the link
  // serializer can shift it out bit 0 first at its own pace
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt; // R20
      rvalid_r <= rvalid_nxt;
    end
  end

  // configuration: clear-on-read first, then host write, then flag set,
  // so a conversion ending in the same cycle as a read still sets
  always_comb begin
    config_nxt = config_r;
    if (flags_read && !config_r[LATCH_BIT]) begin
      config_nxt[OVER_BIT]  = 1'b0; // R10
      config_nxt[UNDER_BIT] = 1'b0; // R10
    end
    if (cfg_wr) begin
      config_nxt = (req.wdata & CONFIG_WMASK) |
                   (config_nxt & ~CONFIG_WMASK); // R6 R7 R11 R12
    end
    // flags are sticky until a read with bit 10 clear, so a pass never clears them
    if (conv_done && over_limit_flag) begin
      config_nxt[OVER_BIT] = 1'b1; // R8
    end
    if (conv_done && under_limit_flag) begin
      config_nxt[UNDER_BIT] = 1'b1; // R9
    end
  end

  // configuration register; flags and reserved bits are only set
  // by the logic above, never by a host write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      config_r <= CONFIG_RESET; // R13
    end else begin
      config_r <= config_nxt;
    end
  end

  // result takes each finished conversion in the current layout
  always_comb begin
    result_nxt = result_r;
    if (conv_done) begin
      result_nxt = conv_word; // R4 R5
    end
  end

  // result register; reads zero until the first conversion lands
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_r <= RESULT_RESET; // R3
    end else begin
      result_r <= result_nxt;
    end
  end

  // both limits share one register shape; the mask follows the layout
  limit_reg #(
    .RESET_VALUE (LOW_RESET)
  ) low_limit_i ( // R14 R15
    .clock  (clock),
    .resetn (resetn),
    .wr_en  (low_wr),
    .wdata  (req.wdata),
    .mask   (thr_mask),
    .value  (low_r)
  );

  limit_reg #(
    .RESET_VALUE (HIGH_RESET)
  ) high_limit_i ( // R16
    .clock  (clock),
    .resetn (resetn),
    .wr_en  (high_wr),
    .wdata  (req.wdata),
    .mask   (thr_mask),
    .value  (high_r)
  );

  // period from rate select
  always_comb begin
    case (config_r[RATE_HI_BIT:RATE_LO_BIT]) // R7
      2'h0:    period = PERIOD_CYC_0;
      2'h1:    period = PERIOD_CYC_1;
      2'h2:    period = PERIOD_CYC_2;
      default: period = PERIOD_CYC_3;
    endcase
  end

  // conversion mode decode; both 1x codes mean continuous,
  // and shutdown is simply neither of the two
  assign continuous  = config_r[MODE_HI_BIT]; // R11
  assign single_shot = config_r[MODE_HI_BIT:MODE_LO_BIT] == MODE_SINGLE; // R11

  // conversion scheduler; a single shot runs once per configuration
  // write, continuous restarts when the selected period has run out
  always_comb begin
    state_nxt       = state_r;
    timer_nxt       = timer_r;
    start_nxt       = 1'b0;
    single_done_nxt = single_done_r;
    case (state_r)
      CONV_IDLE: begin
        if (continuous || (single_shot && !single_done_r)) begin // R11
          start_nxt = 1'b1;
          timer_nxt = 32'h0;
          state_nxt = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        timer_nxt = timer_r + 32'h1;
        if (conv.valid) begin
          state_nxt = CONV_WAIT;
          if (!continuous) begin
            single_done_nxt = 1'b1; // R22
          end
        end
      end
      CONV_WAIT: begin
        // the period counts from the start pulse, not from the answer
        timer_nxt = timer_r + 32'h1;
        if (!continuous) begin
          state_nxt = CONV_IDLE; // R22
        end else if (timer_r + 32'h1 >= period) begin
          state_nxt = CONV_IDLE; // R22
        end
      end
      default: state_nxt = CONV_IDLE;
    endcase
    // a fresh configuration write re-arms the single shot
    if (cfg_wr) begin
      single_done_nxt = 1'b0;
    end
  end

  // scheduler state, period timer, start pulse and single-shot memory
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r       <= CONV_IDLE;
      timer_r       <= 32'h0;
      start_r       <= 1'b0;
      single_done_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      timer_r       <= timer_nxt;
      start_r       <= start_nxt;
      single_done_r <= single_done_nxt;
    end
  end

  // outputs come straight from registers
  assign rdata                 = rdata_r;
  assign rvalid                = rvalid_r;
  assign conv_start            = start_r;
  assign int_enable            = config_r[INT_EN_BIT]; // R6
  assign extended_range_select = config_r[EXT_BIT];

endmodule

// one threshold register: masked write, fixed reset value
module limit_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] mask,
  output logic [15:0]      value
);
  logic [15:0] value_r, value_nxt;

  // the mask drops reserved bits and, in normal layout, the indicator bit
  always_comb begin
    value_nxt = value_r;
    if (wr_en) begin
      value_nxt = wdata & mask; // R18
    end
  end

  // same reset in both layouts; the host rewrites after a layout change
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      value_r <= RESET_VALUE; // R17
    end else begin
      value_r <= value_nxt;
    end
  end

  // value comes straight from the flop
  assign value = value_r;
endmodule

// file: temp_sensor_register_set_assertions.sv
`timescale 1ns/1ps
// port-level watcher for the register set
module reg_set_checker
  import temp_regs_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire reg_req_s    req,
  input wire conv_res_s   conv,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        conv_start,
  input wire logic        int_enable,
  input wire logic        extended_range_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // read strobe and configuration write strobe
  wire logic rd = req.valid && !req.write;
  wire logic wc = req.valid && req.write && req.ptr == PTR_CONFIG;
  AST_READ_ANSWER: assert property (rd |=> rvalid)
    else $error("read not answered");
  AST_NO_STRAY: assert property (!rd |=> !rvalid)
    else $error("rvalid without read");
  AST_RDATA_HOLD: assert property ($changed(rdata) |-> rvalid)
    else $error("rdata moved without rvalid");
  AST_INT_EN: assert property (wc |=> int_enable == $past(req.wdata[15]))
    else $error("interrupt enable not taken");
  AST_EXT_SEL: assert property (wc |=> extended_range_select == $past(req.wdata[7]))
    else $error("layout select not taken");
  AST_RES_LOW: assert property (rd && req.ptr == PTR_RESULT |=> rdata[2:0] == 3'h0)
    else $error("result low bits set");
  AST_CFG_RSV: assert property (rd && req.ptr == PTR_CONFIG |=> rdata[6:0] == 7'h00)
    else $error("config reserved bits set");
  AST_THR_RSV: assert property (rd && req.ptr[1] |=> rdata[2:0] == 3'h0)
    else $error("threshold low bits set");
  AST_SHUTDOWN: assert property (wc && req.wdata[9:8] == 2'h0 |-> ##2 !conv_start [*8])
    else $error("start during shutdown");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than a pulse");
  // main scenarios reached
  cover property (rd ##1 rvalid);
  cover property (conv_start);
  cover property (conv.valid);
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import temp_regs_pkg::*;
  logic        clock;
  logic        resetn;
  reg_req_s    req;
  conv_res_s   conv;
  logic [15:0] rdata;
  logic        rvalid;
  logic        conv_start;
  logic        int_enable;
  logic        extended_range_select;
  logic [12:0] temp_in;
  logic [15:0] q;
  logic [15:0] starts;
  int          fail_count;
  int          n_checks;

  temp_sensor_register_set temp_sensor_register_set_i (.clock(clock), .resetn(resetn),
    .req(req), .conv(conv), .rdata(rdata), .rvalid(rvalid), .conv_start(conv_start),
    .int_enable(int_enable), .extended_range_select(extended_range_select));
  conv_frontend_model conv_frontend_model_i (.clock(clock), .resetn(resetn),
    .conv_start(conv_start), .temp_in(temp_in), .conv(conv));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task results;
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one access; read data is sampled in the cycle rvalid stands
  task acc(input logic w, input logic [1:0] p, input logic [15:0] d);
    @(posedge clock);
    req <= '{1'b1, w, p, d};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    q = rdata;
    if (!w) chk({15'h0, rvalid}, 16'h1);
  endtask
  task rd(input logic [1:0] p, input logic [15:0] e);
    acc(1'b0, p, 16'h0);
    chk(q, e);
  endtask
  // config write kicks a single conversion; bounded wait for its answer
  task run_conv(input logic [15:0] cfg, input logic [12:0] t);
    temp_in <= t;
    acc(1'b1, PTR_CONFIG, cfg);
    for (int i = 0; i < 40 && conv.valid !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (conv.valid !== 1'b1) begin
      fail_count++;
      results;
    end
    repeat (2) @(posedge clock);
  endtask

  task t_defaults;
    rd(PTR_RESULT, RESULT_RESET);
    rd(PTR_CONFIG, CONFIG_RESET);
    rd(PTR_LOW, LOW_RESET);
    rd(PTR_HIGH, HIGH_RESET);
    chk({14'h0, int_enable, extended_range_select}, 16'h0);
  endtask
  // refused bits on every register, then host restores thresholds
  task t_masks;
    acc(1'b1, PTR_RESULT, 16'hFFFF);
    rd(PTR_RESULT, 16'h0000);
    acc(1'b1, PTR_LOW, 16'hFFFF);
    rd(PTR_LOW, THR_MASK_STD);
    acc(1'b1, PTR_CONFIG, 16'hFCFF);
    rd(PTR_CONFIG, 16'hE480);
    chk({14'h0, int_enable, extended_range_select}, 16'h3);
    acc(1'b1, PTR_HIGH, 16'hFFFF);
    rd(PTR_HIGH, THR_MASK_EXT);
    acc(1'b1, PTR_CONFIG, 16'h0000);
    acc(1'b1, PTR_LOW, LOW_RESET);
    acc(1'b1, PTR_HIGH, HIGH_RESET);
  endtask
  task t_over;
    run_conv(16'h0100, 13'h0400);
    rd(PTR_RESULT, 16'h4000);
    rd(PTR_CONFIG, 16'h1100);
    rd(PTR_CONFIG, 16'h0100);
    // a single shot must not start again by itself
    starts = 16'h0;
    repeat (20) begin
      @(posedge clock);
      #1;
      starts = starts + {15'h0, conv_start};
    end
    chk(starts, 16'h0);
  endtask
  task t_under;
    run_conv(16'h0500, 13'h1F00);
    rd(PTR_RESULT, 16'hF000);
    rd(PTR_CONFIG, 16'h0D00);
    rd(PTR_CONFIG, 16'h0D00);
  endtask
  task t_ext;
    run_conv(16'h0180, 13'h0F01);
    rd(PTR_RESULT, 16'h7808);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    resetn     = 1'b0;
    req        = '0;
    temp_in    = '0;
    fail_count = 0;
    n_checks   = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_defaults;
    t_masks;
    t_over;
    t_under;
    t_ext;
    results;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    results;
  end
endmodule

bind temp_sensor_register_set reg_set_checker reg_set_checker_i (.clock(clock),
  .resetn(resetn), .req(req), .conv(conv), .rdata(rdata), .rvalid(rvalid),
  .conv_start(conv_start), .int_enable(int_enable),
  .extended_range_select(extended_range_select));
